// File: asps_top.v
// Power states, reset, detection reporting and switching of the accessory switch
// Summary of operation
// RQ1 - Active-low interrupt output prompts the host to read status.
// RQ2 - Interrupt also asserted on identification line or attach status change.
// RQ3 - Control bit selects manual host routing or automatic switching.
// RQ4 - Factory cables route data lines to UART or USB path.
// RQ5 - Detection and switching run only while battery supply is valid.
// RQ6 - I2C and interrupt work only with I/O and battery supplies valid.
// RQ7 - Charging enabled whenever bus supply valid, even without battery.
// RQ8 - Any supply order reaches correct operation; no sequence needed.
// RQ9 - Power application resets internal state before detection or communication.
// RQ10 - Default register values give working operation without configuration.
// RQ11 - Both attach and detach are detected and reported.
// RQ12 - Automatic mode sets switches from the detection result.
// RQ13 - Host drives serial clock; device is an I2C target.
// RQ14 - Serial data driven only open-drain, released by default.
// RQ15 - Any reset loads defaults, opens all switches, enters standby.
// RQ16 - Power-on reset on first rising edge of battery or bus supply.
// RQ17 - Writing reset bit at address 1BH acts like hardware reset.
// RQ18 - I2C target supports fast mode up to 400 kHz.
// RQ19 - No battery or bus supply: all off, interrupt released.
`include "asps_map.vh"
`default_nettype none
module asps_top (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire bat_valid_i,
   input wire bus_valid_i,
   input wire io_supply_i,
   input wire attach_i,
   input wire [4:0] accessory_id_line_i,
   input wire scl_i,
   input wire sda_i,
   output wire sda_o,
   output wire sda_oe_o,
   output reg host_interrupt_n_o,
   output reg detect_en_o,
   output reg charge_en_o,
   output reg host_comm_en_o,
   output reg sw_usb_o,
   output reg sw_uart_o
);
   // ----------------------------------------
   // Input synchronisation
   // ----------------------------------------
   wire [8:0] pins_s;
   asps_sync #(
      .WIDTH(9)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i({bat_valid_i, bus_valid_i, io_supply_i, attach_i, accessory_id_line_i}),
      .q_o(pins_s)
   );
   wire bat_s = pins_s[8];
   wire bus_s = pins_s[7];
   wire io_s = pins_s[6];
   wire attach_s = pins_s[5];
   wire [4:0] id_s = pins_s[4:0];
   // SCL and SDA get their own filter so the bus edges stay aligned
   wire [1:0] i2c_s;
   asps_sync #(
      .WIDTH(2)
   ) u_sync_i2c (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i({scl_i, sda_i}),
      .q_o(i2c_s)
   );
   // ----------------------------------------
   // Supply qualification and internal reset
   // ----------------------------------------
   // I/O supply matters only with battery valid; I/O supply alone counts as off
   localparam [5:0] P_OFF = 6'h01;
   localparam [5:0] P_DET = 6'h02;
   localparam [5:0] P_DET_LINK = 6'h04;
   localparam [5:0] P_CHG = 6'h08;
   localparam [5:0] P_ON = 6'h10;
   localparam [5:0] P_ON_LINK = 6'h20;
   reg [5:0] pwr_st;
   reg [5:0] next_pwr_st;
   reg soft_rst;
   always @* begin
      case ({bus_s, bat_s, io_s}) // RQ8
         3'h0: next_pwr_st = P_OFF; // RQ19
         3'h1: next_pwr_st = P_OFF; // RQ19
         3'h2: next_pwr_st = P_DET; // RQ5
         3'h3: next_pwr_st = P_DET_LINK; // RQ6
         3'h4: next_pwr_st = P_CHG; // RQ7
         3'h5: next_pwr_st = P_CHG; // RQ7
         3'h6: next_pwr_st = P_ON;
         3'h7: next_pwr_st = P_ON_LINK;
         default: next_pwr_st = P_OFF;
      endcase
   end
   // Enables decode the next state so no cycle of latency is added
   wire det_en = |(next_pwr_st & (P_DET | P_DET_LINK | P_ON | P_ON_LINK)); // RQ5
   wire comm_en = |(next_pwr_st & (P_DET_LINK | P_ON_LINK)); // RQ6
   wire chg_en = |(next_pwr_st & (P_CHG | P_ON | P_ON_LINK)); // RQ7
   // Power-on reset on the first rising edge of either main supply
   wire por_rst = pwr_st[0] & ~next_pwr_st[0]; // RQ16
   wire int_rst = rst_i | (ce_i & (por_rst | soft_rst)); // RQ9 RQ17
   always @(posedge clk_i) begin
      if (rst_i) begin
         pwr_st <= P_OFF;
      end else if (ce_i) begin
         pwr_st <= next_pwr_st; // RQ8
      end
   end
   // ----------------------------------------
   // I2C target
   // ----------------------------------------
   wire [7:0] ptr;
   wire [7:0] wdata;
   wire wr_stb;
   wire rd_stb;
   reg [7:0] rdata;
   // Oversampling at 50 MHz leaves wide margin for a 400 kHz clock
   // Soft reset spares the bus engine so the reset write is still acknowledged
   asps_i2c u_i2c (
      .clk_i(clk_i),
      .rst_i(rst_i | (ce_i & por_rst)),
      .ce_i(ce_i),
      .en_i(comm_en), // RQ6 RQ18
      .scl_i(i2c_s[1]),
      .sda_i(i2c_s[0]),
      .rdata_i(rdata),
      .sda_o(sda_o),
      .sda_oe_o(sda_oe_o),
      .ptr_o(ptr),
      .wdata_o(wdata),
      .wr_stb_o(wr_stb),
      .rd_stb_o(rd_stb)
   );
   always @(posedge clk_i) begin
      if (rst_i) begin
         soft_rst <= 1'b0;
      end else if (ce_i) begin
         soft_rst <= wr_stb & (ptr == `ASPS_OFS_RESET) & wdata[`ASPS_RESET_BIT]; // RQ17
      end
   end
   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   reg [7:0] ctrl;
   reg [1:0] man_sw;
   wire int_mask = ctrl[`ASPS_CTRL_MASK_BIT];
   wire manual = ctrl[`ASPS_CTRL_MANUAL_BIT]; // RQ3
   always @(posedge clk_i) begin
      if (int_rst) begin
         ctrl <= `ASPS_CTRL_RST; // RQ10 RQ15
         man_sw <= `ASPS_MANSW_RST;
      end else if (ce_i && wr_stb) begin
         if (ptr == `ASPS_OFS_CTRL) begin
            ctrl <= wdata;
         end
         if (ptr == `ASPS_OFS_MANSW) begin
            man_sw <= wdata[1:0];
         end
      end
   end
   // ----------------------------------------
   // Detection events
   // ----------------------------------------
   reg attached;
   reg [4:0] id_code;
   reg [2:0] int_stat;
   wire ev_attach = det_en & attach_s & ~attached; // RQ11
   wire ev_detach = det_en & ~attach_s & attached; // RQ11
   wire ev_idchg = det_en & (id_s != id_code); // RQ2
   wire [2:0] ev = {ev_idchg, ev_detach, ev_attach};
   wire rd_int = rd_stb & (ptr == `ASPS_OFS_INT);
   localparam [2:0] INT_RST = `ASPS_INT_RST;
   always @(posedge clk_i) begin
      if (int_rst || (ce_i && !det_en)) begin
         attached <= 1'b0;
         id_code <= `ASPS_ID_OPEN;
      end else if (ce_i) begin
         attached <= attach_s;
         id_code <= id_s;
      end
   end
   // Clear on read; a fresh event in the same cycle wins so none is lost
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : stat_bit
         always @(posedge clk_i) begin
            if (int_rst || (ce_i && !det_en)) begin
               int_stat[g] <= INT_RST[g];
            end else if (ce_i) begin
               if (ev[g]) begin
                  int_stat[g] <= 1'b1;
               end else if (rd_int) begin
                  int_stat[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate
   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always @* begin
      case (ptr)
         `ASPS_OFS_CTRL: rdata = ctrl;
         `ASPS_OFS_INT: rdata = {5'h00, int_stat};
         `ASPS_OFS_STAT: rdata = {2'h0, attached, id_code};
         `ASPS_OFS_MANSW: rdata = {6'h00, man_sw};
         default: rdata = 8'h00;
      endcase
   end
   // ----------------------------------------
   // Switch routing
   // ----------------------------------------
   reg next_usb;
   reg next_uart;
   always @* begin
      next_usb = 1'b0;
      next_uart = 1'b0;
      if (manual) begin
         next_usb = man_sw[`ASPS_MANSW_USB_BIT];
         // Never close both paths at once; USB wins
         next_uart = man_sw[`ASPS_MANSW_UART_BIT] & ~man_sw[`ASPS_MANSW_USB_BIT]; // RQ4
      end else if (attached) begin // RQ12
         case (id_code)
            `ASPS_ID_USB_OFF, `ASPS_ID_USB_ON: next_usb = 1'b1; // RQ4
            `ASPS_ID_UART_OFF, `ASPS_ID_UART_ON: next_uart = 1'b1; // RQ4
            `ASPS_ID_OPEN: next_usb = bus_s;
            default: next_usb = 1'b0;
         endcase
      end
   end
   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (int_rst) begin
         host_interrupt_n_o <= 1'b1;
         detect_en_o <= 1'b0;
         charge_en_o <= 1'b0;
         host_comm_en_o <= 1'b0;
         sw_usb_o <= 1'b0; // RQ15
         sw_uart_o <= 1'b0;
      end else if (ce_i) begin
         // Released whenever communication is unpowered
         host_interrupt_n_o <= ~(comm_en & ~int_mask & (|int_stat)); // RQ1 RQ2 RQ6 RQ19
         detect_en_o <= det_en; // RQ5 RQ19
         charge_en_o <= chg_en; // RQ7
         host_comm_en_o <= comm_en;
         sw_usb_o <= det_en & next_usb;
         sw_uart_o <= det_en & next_uart;
      end
   end
endmodule
`default_nettype wire

// File: asps_map.vh
// Constants for the accessory switch power-state block
`ifndef ASPS_MAP_VH
`define ASPS_MAP_VH
// ----------------------------------------
// Target address and register offsets
// ----------------------------------------
`define ASPS_I2C_ADDR 7'h25
`define ASPS_OFS_CTRL 8'h02
`define ASPS_OFS_INT 8'h03
`define ASPS_OFS_STAT 8'h0A
`define ASPS_OFS_MANSW 8'h13
`define ASPS_OFS_RESET 8'h1B
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASPS_CTRL_MASK_BIT 0
`define ASPS_CTRL_MANUAL_BIT 2
`define ASPS_INT_ATTACH_BIT 0
`define ASPS_INT_DETACH_BIT 1
`define ASPS_INT_IDCHG_BIT 2
`define ASPS_MANSW_USB_BIT 0
`define ASPS_MANSW_UART_BIT 1
`define ASPS_RESET_BIT 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ASPS_CTRL_RST 8'h00
`define ASPS_MANSW_RST 2'h0
`define ASPS_INT_RST 3'h0
// ----------------------------------------
// Identification codes of factory cables and of an open line
// ----------------------------------------
`define ASPS_ID_USB_OFF 5'h18
`define ASPS_ID_USB_ON 5'h19
`define ASPS_ID_UART_OFF 5'h1C
`define ASPS_ID_UART_ON 5'h1D
`define ASPS_ID_OPEN 5'h1F
`endif

// File: asps_sync.v
// Three-stage input synchroniser with agreement filter
`default_nettype none
module asps_sync #(
   parameter WIDTH = 1
) (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire [WIDTH-1:0] d_i,
   output reg [WIDTH-1:0] q_o
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : bit_sync
         // Output moves only once stages two and three agree
         always @(posedge clk_i) begin
            if (rst_i) begin
               stage1[g] <= 1'b0;
               stage2[g] <= 1'b0;
               stage3[g] <= 1'b0;
               q_o[g] <= 1'b0;
            end else if (ce_i) begin
               stage1[g] <= d_i[g];
               stage2[g] <= stage1[g];
               stage3[g] <= stage2[g];
               if (stage2[g] == stage3[g]) begin
                  q_o[g] <= stage3[g];
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// File: asps_i2c.v
// Oversampled I2C target with register pointer
`include "asps_map.vh"
`default_nettype none
module asps_i2c (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire en_i,
   input wire scl_i,
   input wire sda_i,
   input wire [7:0] rdata_i,
   output reg sda_o,
   output reg sda_oe_o,
   output reg [7:0] ptr_o,
   output reg [7:0] wdata_o,
   output reg wr_stb_o,
   output reg rd_stb_o
);
   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_ADDR = 7'h02;
   localparam [6:0] S_ACKA = 7'h04;
   localparam [6:0] S_WR = 7'h08;
   localparam [6:0] S_ACKW = 7'h10;
   localparam [6:0] S_RD = 7'h20;
   localparam [6:0] S_ACKR = 7'h40;
   reg [6:0] st;
   reg [3:0] cnt;
   reg [7:0] sh;
   reg scl_q;
   reg sda_q;
   reg rw;
   reg first;
   reg wrote;
   wire scl_rise = scl_i & ~scl_q;
   wire scl_fall = ~scl_i & scl_q;
   wire start = scl_i & scl_q & sda_q & ~sda_i;
   wire stop = scl_i & scl_q & ~sda_q & sda_i;
   // ----------------------------------------
   // Bit engine
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i || (ce_i && !en_i)) begin
         st <= S_IDLE;
         cnt <= 4'h0;
         sh <= 8'h00;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rw <= 1'b0;
         first <= 1'b0;
         wrote <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0; // RQ14
         ptr_o <= 8'h00;
         wdata_o <= 8'h00;
         wr_stb_o <= 1'b0;
         rd_stb_o <= 1'b0;
      end else if (ce_i) begin
         scl_q <= scl_i;
         sda_q <= sda_i;
         wr_stb_o <= 1'b0;
         rd_stb_o <= 1'b0;
         if (start) begin
            st <= S_ADDR;
            cnt <= 4'h0;
            first <= 1'b1;
            sda_oe_o <= 1'b0;
         end else if (stop) begin
            st <= S_IDLE;
            sda_oe_o <= 1'b0;
         end else if (scl_rise) begin // RQ13
            case (st)
               S_ADDR, S_WR: begin
                  sh <= {sh[6:0], sda_i};
                  cnt <= cnt + 4'h1;
               end
               S_ACKR: begin
                  if (sda_i) begin
                     st <= S_IDLE;
                  end else begin
                     ptr_o <= ptr_o + 8'h01;
                  end
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            case (st)
               S_ADDR: begin
                  if (cnt == 4'h8) begin
                     if (sh[7:1] == `ASPS_I2C_ADDR) begin
                        sda_oe_o <= 1'b1;
                        rw <= sh[0];
                        st <= S_ACKA;
                     end else begin
                        st <= S_IDLE;
                     end
                  end
               end
               S_WR: begin
                  if (cnt == 4'h8) begin
                     sda_oe_o <= 1'b1;
                     st <= S_ACKW;
                     wrote <= ~first;
                     if (first) begin
                        ptr_o <= sh;
                        first <= 1'b0;
                     end else begin
                        wdata_o <= sh;
                        wr_stb_o <= 1'b1;
                     end
                  end
               end
               S_ACKA: begin
                  cnt <= 4'h0;
                  if (rw) begin
                     sh <= rdata_i;
                     rd_stb_o <= 1'b1;
                     sda_oe_o <= ~rdata_i[7];
                     st <= S_RD;
                  end else begin
                     sda_oe_o <= 1'b0;
                     st <= S_WR;
                  end
               end
               S_ACKW: begin
                  sda_oe_o <= 1'b0;
                  cnt <= 4'h0;
                  st <= S_WR;
                  if (wrote) begin
                     ptr_o <= ptr_o + 8'h01;
                  end
               end
               S_RD: begin
                  cnt <= cnt + 4'h1;
                  if (cnt == 4'h7) begin
                     sda_oe_o <= 1'b0;
                     st <= S_ACKR;
                  end else begin
                     sh <= {sh[6:0], 1'b0};
                     sda_oe_o <= ~sh[6];
                  end
               end
               S_ACKR: begin
                  // Reaching here means the master acknowledged; next byte goes out now
                  cnt <= 4'h0;
                  sh <= rdata_i;
                  rd_stb_o <= 1'b1;
                  sda_oe_o <= ~rdata_i[7];
                  st <= S_RD;
               end
               default: begin
                  st <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// File: asps_monitor.sv
// Checker of supply, reset and pin relations of the accessory switch
`default_nettype none
module asps_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic bat_valid_i,
   input wire logic bus_valid_i,
   input wire logic io_supply_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic host_interrupt_n_o,
   input wire logic detect_en_o,
   input wire logic charge_en_o,
   input wire logic host_comm_en_o,
   input wire logic sw_usb_o,
   input wire logic sw_uart_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   // Eight cycles cover the input synchroniser and the output register
   sequence s_bat_off;
      !bat_valid_i [*8];
   endsequence
   sequence s_comm_off;
      !host_comm_en_o [*2];
   endsequence
   property p_det_off;
      disable iff (rst_i) s_bat_off |-> !detect_en_o;
   endproperty
   a_det_off: assert property (p_det_off) else $error("detection on without battery");
   property p_chg_off;
      disable iff (rst_i) !bus_valid_i [*8] |-> !charge_en_o;
   endproperty
   a_chg_off: assert property (p_chg_off) else $error("charging on without bus supply");
   property p_comm_io;
      disable iff (rst_i) !io_supply_i [*8] |-> !host_comm_en_o;
   endproperty
   a_comm_io: assert property (p_comm_io) else $error("host link on without io supply");
   property p_comm_bat;
      disable iff (rst_i) s_bat_off |-> !host_comm_en_o;
   endproperty
   a_comm_bat: assert property (p_comm_bat) else $error("host link on without battery");
   property p_int_off;
      disable iff (rst_i) s_comm_off |-> host_interrupt_n_o;
   endproperty
   a_int_off: assert property (p_int_off) else $error("interrupt low while link off");
   property p_sda_od;
      disable iff (rst_i) sda_oe_o |-> !sda_o;
   endproperty
   a_sda_od: assert property (p_sda_od) else $error("data line driven high");
   property p_sda_comm;
      disable iff (rst_i) s_comm_off |-> !sda_oe_o;
   endproperty
   a_sda_comm: assert property (p_sda_comm) else $error("data line driven while link off");
   // Reset itself is the cause here, so no disable
   property p_rst;
      rst_i |=> host_interrupt_n_o && !detect_en_o && !charge_en_o && !sw_usb_o && !sw_uart_o && !sda_oe_o;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not at defaults after reset");
   property p_sw_excl;
      disable iff (rst_i) !(sw_usb_o && sw_uart_o);
   endproperty
   a_sw_excl: assert property (p_sw_excl) else $error("both data paths closed");
   property p_sw_det;
      disable iff (rst_i) !detect_en_o [*2] |-> !sw_usb_o && !sw_uart_o;
   endproperty
   a_sw_det: assert property (p_sw_det) else $error("switch closed without detection");
endmodule
bind asps_top asps_monitor i_asps_monitor (.clk_i, .rst_i, .bat_valid_i, .bus_valid_i, .io_supply_i, .sda_o,
   .sda_oe_o, .host_interrupt_n_o, .detect_en_o, .charge_en_o, .host_comm_en_o, .sw_usb_o, .sw_uart_o);
`default_nettype wire

// File: asps_host.sv
// Serial bus master model standing in for the host processor
`default_nettype none
module asps_host (
   input wire logic clk_i,
   input wire logic sda_i,
   output var logic scl_o,
   output var logic sda_low_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // Quarter bit of 32 cycles keeps the clock just under 400 kHz
   task automatic q();
      repeat (32) @(posedge clk_i);
      #1;
   endtask
   task automatic start();
      sda_low_o = 1'b0;
      q();
      scl_o = 1'b1;
      q();
      sda_low_o = 1'b1;
      q();
      scl_o = 1'b0;
      q();
   endtask
   task automatic stop();
      sda_low_o = 1'b1;
      q();
      scl_o = 1'b1;
      q();
      sda_low_o = 1'b0;
      q();
   endtask
   task automatic bit_x(input logic b, output logic r);
      sda_low_o = !b;
      q();
      scl_o = 1'b1;
      q();
      r = sda_i;
      q();
      scl_o = 1'b0;
      q();
   endtask
   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r[i]);
      end
      bit_x(mack, a);
      ack = !a;
   endtask
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench of the accessory switch power-state block
`include "asps_map.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic bat_valid_i = 1'b0;
   logic bus_valid_i = 1'b0;
   logic io_supply_i = 1'b0;
   logic attach_i = 1'b0;
   logic [4:0] accessory_id_line_i = `ASPS_ID_OPEN;
   logic scl_i, sda_i, sda_o, sda_oe_o, host_low, host_interrupt_n_o;
   logic detect_en_o, charge_en_o, host_comm_en_o, sw_usb_o, sw_uart_o;
   logic [7:0] outs;
   int mismatches = 0;
   int cmp_count = 0;
   // Pull-up on the data line: low only while someone pulls it
   assign sda_i = !(sda_oe_o | host_low);
   assign outs = {1'b0, host_interrupt_n_o, detect_en_o, charge_en_o, host_comm_en_o, sw_usb_o, sw_uart_o, sda_oe_o};
   always #10 clk_i = ~clk_i;
   asps_top i_asps_top (.clk_i, .rst_i, .ce_i, .bat_valid_i, .bus_valid_i, .io_supply_i, .attach_i,
      .accessory_id_line_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .host_interrupt_n_o, .detect_en_o,
      .charge_en_o, .host_comm_en_o, .sw_usb_o, .sw_uart_o);
   asps_host i_asps_host (.clk_i, .sda_i, .scl_o(scl_i), .sda_low_o(host_low));
   task automatic end_sim();
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wait_int(input logic e);
      int n;
      n = 0;
      while (host_interrupt_n_o !== e && n < 400) begin
         cyc(1);
         n++;
      end
      chk(host_interrupt_n_o, e);
      if (n >= 400)
         end_sim();
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] r;
      logic a;
      i_asps_host.start();
      i_asps_host.xfer({`ASPS_I2C_ADDR, 1'b0}, 1'b1, r, a);
      chk(a, 1'b1);
      i_asps_host.xfer(p, 1'b1, r, a);
      i_asps_host.xfer(d, 1'b1, r, a);
      chk(a, 1'b1);
      i_asps_host.stop();
   endtask
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      logic [7:0] r;
      logic a;
      i_asps_host.start();
      i_asps_host.xfer({`ASPS_I2C_ADDR, 1'b0}, 1'b1, r, a);
      i_asps_host.xfer(p, 1'b1, r, a);
      i_asps_host.start();
      i_asps_host.xfer({`ASPS_I2C_ADDR, 1'b1}, 1'b1, r, a);
      chk(a, 1'b1);
      i_asps_host.xfer(8'hFF, 1'b1, d, a);
      i_asps_host.stop();
   endtask
   task automatic t_power();
      for (int k = 0; k < 8; k++) begin
         {bus_valid_i, bat_valid_i, io_supply_i} = k[2:0];
         cyc(12);
         chk(outs, {2'b01, k[1], k[2], k[1] & k[0], 3'b000});
      end
   endtask
   task automatic t_auto();
      logic [7:0] d;
      attach_i = 1'b1;
      accessory_id_line_i = `ASPS_ID_USB_ON;
      wait_int(1'b0);
      cyc(4);
      chk({sw_usb_o, sw_uart_o}, 2'b10);
      rd(`ASPS_OFS_INT, d);
      chk(d, 8'h05);
      wait_int(1'b1);
      accessory_id_line_i = `ASPS_ID_UART_OFF;
      wait_int(1'b0);
      cyc(4);
      chk({sw_usb_o, sw_uart_o}, 2'b01);
      rd(`ASPS_OFS_INT, d);
      chk(d, 8'h04);
      attach_i = 1'b0;
      wait_int(1'b0);
      cyc(4);
      chk({sw_usb_o, sw_uart_o}, 2'b00);
      rd(`ASPS_OFS_INT, d);
      chk(d, 8'h02);
   endtask
   task automatic t_manual();
      logic [7:0] d;
      logic [7:0] r;
      logic a;
      wr(`ASPS_OFS_CTRL, 8'h04);
      wr(`ASPS_OFS_MANSW, 8'h02);
      cyc(4);
      chk({sw_usb_o, sw_uart_o}, 2'b01);
      wr(`ASPS_OFS_RESET, 8'h01);
      cyc(4);
      chk({sw_usb_o, sw_uart_o}, 2'b00);
      rd(`ASPS_OFS_CTRL, d);
      chk(d, 8'h00);
      i_asps_host.start();
      i_asps_host.xfer({`ASPS_I2C_ADDR ^ 7'h01, 1'b0}, 1'b1, r, a);
      chk(a, 1'b0);
      i_asps_host.stop();
   endtask
   task automatic t_por();
      logic [7:0] d;
      wait_int(1'b0);
      wr(`ASPS_OFS_CTRL, 8'h05);
      wait_int(1'b1);
      {bus_valid_i, bat_valid_i} = 2'b00;
      cyc(12);
      chk(outs, 8'h40);
      bat_valid_i = 1'b1;
      cyc(12);
      rd(`ASPS_OFS_CTRL, d);
      chk(d, 8'h00);
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      cyc(2);
      chk(outs, 8'h40);
      t_power();
      t_auto();
      t_manual();
      t_por();
      end_sim();
   end
   initial begin
      repeat (100000) @(posedge clk_i);
      mismatches++;
      end_sim();
   end
endmodule
`default_nettype wire
